// >>> synth_rx_control_consts.svh
`ifndef SYNTH_RX_CONTROL_CONSTS_SVH
`define SYNTH_RX_CONTROL_CONSTS_SVH

// Register byte addresses on the APB slave.
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_BLOCK1 12'h008
`define ADDR_BLOCK2 12'h00C

// Control register fields.
`define CTRL_WIDTH 12
`define CTRL_RESET 12'h000
`define CTRL_MON_SEL 2
`define CTRL_FORCE 3
`define CTRL_ON 4
`define CTRL_RX_EST_LO 5
`define CTRL_OSC_EST_LO 7
`define CTRL_RATE_LO 9
`define CTRL_SYNTH_EN 11

// Status register fields.
`define STAT_BUSY 0
`define STAT_RX_SETTLED 1
`define STAT_OSC_SETTLED 2
`define STAT_RX_EN 3
`define STAT_OSC_EN 4
`define STAT_MON 6
`define STAT_IRQ 7

// Synthesizer word layout.
`define BLOCK_BITS 24
`define BLOCK_RESET 24'h000000
`define PAUSE_BIT 5'd12
`define LAST_BIT 5'd23

// Clock rates and timing figures.
`define CLK_HZ 125000000
`define CLK_KHZ 125000
`define DEC_CLK_HZ 76800
`define PAUSE_512 7'd119
`define PAUSE_1200 7'd33
`define PAUSE_2400 7'd1
`define RX_EST_MS0 6'd5
`define RX_EST_MS1 6'd10
`define RX_EST_MS2 6'd15
`define RX_EST_MS3 6'd30
`define OSC_EST_MS0 6'd20
`define OSC_EST_MS1 6'd30
`define OSC_EST_MS2 6'd40
`define OSC_EST_MS3 6'd50

`endif

// >>> synth_rx_control_pkg.sv
package synth_rx_control_pkg;

	typedef enum logic [2:0]
	{
		SYN_IDLE = 3'b000,
		SYN_LOW = 3'b001,
		SYN_HIGH = 3'b011,
		SYN_LATCH = 3'b010,
		SYN_GAP = 3'b110
	} synth_state_t;

	typedef logic [1:0] rate_sel_t;
	typedef logic [1:0] est_sel_t;

endpackage

// >>> est_timer.sv
`timescale 1ns/10ps
`include "synth_rx_control_consts.svh"

module est_timer
	import synth_rx_control_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Enable and timing.
	input wire logic enable,
	input wire logic ms_tick,
	input wire logic [5:0] target_ms,
	// Result.
	output logic settled
);
	logic [5:0] count_reg;
	logic [5:0] count_next;
	logic settled_reg;
	logic settled_next;

	// The count restarts whenever the enable drops, so each enable period is timed anew.
	assign count_next = !enable ? 6'h00 : (ms_tick && count_reg != target_ms) ? count_reg + 6'h01 : count_reg;
	assign settled_next = enable && (count_reg == target_ms);
	assign settled = settled_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_reg <= 6'h00;
			settled_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			settled_reg <= settled_next;
		end
	end
endmodule // est_timer

// >>> synth_shifter.sv
`timescale 1ns/10ps
`include "synth_rx_control_consts.svh"

module synth_shifter
	import synth_rx_control_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Control.
	input wire logic start,
	input wire logic dec_tick,
	input wire synth_rx_control_pkg::rate_sel_t rate_sel,
	input wire logic [23:0] block1,
	input wire logic [23:0] block2,
	output logic busy,
	// Synthesizer pins.
	output logic synth_serial_data,
	output logic synth_serial_clock,
	output logic synth_latch_pulse
);
	synth_state_t state_reg;
	synth_state_t state_next;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic [23:0] block2_reg;
	logic [4:0] bit_reg;
	logic [4:0] bit_next;
	logic [6:0] wait_reg;
	logic [6:0] wait_next;
	logic second_reg;
	logic second_next;
	logic data_reg;
	logic data_next;
	logic clk_reg;
	logic clk_next;
	logic latch_reg;
	logic latch_next;
	wire logic [6:0] pause = (rate_sel == 2'd0) ? `PAUSE_512 : (rate_sel == 2'd1) ? `PAUSE_1200 : `PAUSE_2400;
	wire logic [6:0] low_target = (bit_reg == `PAUSE_BIT) ? pause : 7'h00;
	wire logic wait_done = (wait_reg == low_target);
	wire logic gap_done = (wait_reg == pause);

	assign busy = (state_reg != SYN_IDLE);
	assign synth_serial_data = data_reg;
	assign synth_serial_clock = clk_reg;
	assign synth_latch_pulse = latch_reg;

	always_comb
	begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_next = bit_reg;
		wait_next = wait_reg;
		second_next = second_reg;
		data_next = data_reg;
		clk_next = clk_reg;
		latch_next = 1'b0;
		case (state_reg)
			SYN_IDLE:
			begin
				if (start)
				begin
					// The first bit is put out while the clock is still low.
					shift_next = block1;
					data_next = block1[23];
					bit_next = 5'd0;
					wait_next = 7'h00;
					second_next = 1'b0;
					state_next = SYN_LOW;
				end
			end
			SYN_LOW:
			begin
				if (dec_tick)
				begin
					if (wait_done)
					begin
						clk_next = 1'b1;
						state_next = SYN_HIGH;
					end
					else
					begin
						wait_next = wait_reg + 7'h01;
					end
				end
			end
			SYN_HIGH:
			begin
				if (dec_tick)
				begin
					clk_next = 1'b0;
					wait_next = 7'h00;
					if (bit_reg == `LAST_BIT)
					begin
						data_next = 1'b0;
						latch_next = 1'b1;
						state_next = SYN_LATCH;
					end
					else
					begin
						shift_next = {shift_reg[22:0], 1'b0};
						data_next = shift_reg[22];
						bit_next = bit_reg + 5'd1;
						state_next = SYN_LOW;
					end
				end
			end
			SYN_LATCH:
			begin
				latch_next = !dec_tick;
				if (dec_tick)
				begin
					state_next = second_reg ? SYN_IDLE : SYN_GAP;
				end
			end
			SYN_GAP:
			begin
				if (dec_tick)
				begin
					if (gap_done)
					begin
						shift_next = block2_reg;
						data_next = block2_reg[23];
						bit_next = 5'd0;
						second_next = 1'b1;
						wait_next = 7'h00;
						state_next = SYN_LOW;
					end
					else
					begin
						wait_next = wait_reg + 7'h01;
					end
				end
			end
			default:
			begin
				state_next = SYN_IDLE;
				clk_next = 1'b0;
				data_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= SYN_IDLE;
			shift_reg <= `BLOCK_RESET;
			block2_reg <= `BLOCK_RESET;
			bit_reg <= 5'd0;
			wait_reg <= 7'h00;
			second_reg <= 1'b0;
			data_reg <= 1'b0;
			clk_reg <= 1'b0;
			latch_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			if (state_reg == SYN_IDLE && start)
			begin
				block2_reg <= block2;
			end
			bit_reg <= bit_next;
			wait_reg <= wait_next;
			second_reg <= second_next;
			data_reg <= data_next;
			clk_reg <= clk_next;
			latch_reg <= latch_next;
		end
	end

	property p_data_on_falling;
		@(posedge pclk) disable iff (!presetn)
		$changed(synth_serial_data) |-> !synth_serial_clock;
	endproperty
	a_data_on_falling: assert property (p_data_on_falling) else $error("Serial data changed while clock high.");

	property p_pause_bit;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SYN_LOW && bit_reg == `PAUSE_BIT && dec_tick && wait_reg < pause) |=> !synth_serial_clock;
	endproperty
	a_pause_bit: assert property (p_pause_bit) else $error("Pause in thirteenth bit cut short.");

	property p_latch_after_last;
		@(posedge pclk) disable iff (!presetn)
		$rose(synth_latch_pulse) |-> $past(bit_reg) == `LAST_BIT && $past(state_reg) == SYN_HIGH;
	endproperty
	a_latch_after_last: assert property (p_latch_after_last) else $error("Latch pulse before the last bit.");

	property p_gap_pause;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SYN_GAP && dec_tick && wait_reg < pause) |=> state_reg == SYN_GAP && !synth_serial_clock;
	endproperty
	a_gap_pause: assert property (p_gap_pause) else $error("Inter-block delay cut short.");

	property p_idle_low;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SYN_IDLE) |-> !synth_serial_clock && !synth_serial_data && !synth_latch_pulse;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("Synthesizer lines not at rest.");

	property p_msb_first;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == SYN_IDLE && start) |=> synth_serial_data == $past(block1[23]) && bit_reg == 5'd0;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Transfer did not start with block 1 MSB.");
endmodule // synth_shifter

// >>> synth_rx_control.sv
`timescale 1ns/10ps
`include "synth_rx_control_consts.svh"

module synth_rx_control
	import synth_rx_control_pkg::*;
#(
	parameter int CYC_PER_MS = `CLK_KHZ,
	parameter int DEC_DIV = `CLK_HZ / `DEC_CLK_HZ
)
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoder timing and pins.
	input wire logic rx_window_req,
	input wire logic battery_sense_in,
	output logic rx_enable_out,
	output logic osc_enable_out,
	output logic irq_out,
	// Synthesizer interface.
	output logic synth_serial_data,
	output logic synth_serial_clock,
	output logic synth_latch_pulse
);
	import synth_rx_control_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [`CTRL_WIDTH-1:0] ctrl_reg;
	logic [23:0] block1_reg;
	logic [23:0] block2_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] read_mux;
	logic batt_meta_reg;
	logic batt_sync_reg;
	logic batt_sample_reg;
	logic rx_en_reg;
	logic osc_en_reg;
	logic rx_prev_reg;
	logic mon_prev_reg;
	logic irq_reg;
	logic on_prev_reg;
	logic start_pend_reg;
	logic [31:0] ms_cnt_reg;
	logic ms_tick_reg;
	logic [31:0] dec_cnt_reg;
	logic dec_tick_reg;
	logic synth_busy;
	logic rx_settled;
	logic osc_settled;
	logic seen_fall_reg;

	// Bus decode.
	wire logic access = psel && penable && !pready_reg;
	wire logic done = psel && penable && pready_reg;
	wire logic wr_done = done && pwrite;
	wire logic hit_ctrl = (paddr == `ADDR_CTRL);
	wire logic hit_status = (paddr == `ADDR_STATUS);
	wire logic hit_blk1 = (paddr == `ADDR_BLOCK1);
	wire logic hit_blk2 = (paddr == `ADDR_BLOCK2);
	wire logic mapped = hit_ctrl || hit_status || hit_blk1 || hit_blk2;
	wire logic status_read = done && !pwrite && hit_status;

	// Control fields.
	wire logic mon_sel = ctrl_reg[`CTRL_MON_SEL];
	wire logic force_on = ctrl_reg[`CTRL_FORCE];
	wire logic dec_on = ctrl_reg[`CTRL_ON];
	wire logic synth_en = ctrl_reg[`CTRL_SYNTH_EN];
	wire est_sel_t rx_est_sel = ctrl_reg[`CTRL_RX_EST_LO +: 2];
	wire est_sel_t osc_est_sel = ctrl_reg[`CTRL_OSC_EST_LO +: 2];
	wire rate_sel_t rate_sel = ctrl_reg[`CTRL_RATE_LO +: 2];

	// Establishment times and monitor source.
	wire logic [5:0] rx_target = (rx_est_sel == 2'd0) ? `RX_EST_MS0 : (rx_est_sel == 2'd1) ? `RX_EST_MS1 :
		(rx_est_sel == 2'd2) ? `RX_EST_MS2 : `RX_EST_MS3;
	wire logic [5:0] osc_target = (osc_est_sel == 2'd0) ? `OSC_EST_MS0 : (osc_est_sel == 2'd1) ? `OSC_EST_MS1 :
		(osc_est_sel == 2'd2) ? `OSC_EST_MS2 : `OSC_EST_MS3;
	wire logic mon_bit = mon_sel ? rx_en_reg : batt_sample_reg;
	wire logic mon_change = (mon_bit != mon_prev_reg);
	wire logic rx_fall = rx_prev_reg && !rx_en_reg;
	wire logic on_rise = dec_on && !on_prev_reg;
	wire logic rx_next = force_on || (dec_on && rx_window_req);
	wire logic osc_next = force_on || dec_on || synth_busy;

	assign read_mux = hit_ctrl ? {20'h00000, ctrl_reg} :
		hit_status ? {24'h000000, irq_reg, mon_bit, 1'b0, osc_en_reg, rx_en_reg, osc_settled, rx_settled, synth_busy} :
		hit_blk1 ? {8'h00, block1_reg} :
		hit_blk2 ? {8'h00, block2_reg} : 32'h00000000;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign rx_enable_out = rx_en_reg;
	assign osc_enable_out = osc_en_reg;
	assign irq_out = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave with one wait state: read data is registered on the same edge that raises pready.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			pready_reg <= access;
			if (access)
			begin
				prdata_reg <= pwrite ? 32'h00000000 : read_mux;
				pslverr_reg <= !mapped;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= `CTRL_RESET;
			block1_reg <= `BLOCK_RESET;
			block2_reg <= `BLOCK_RESET;
		end
		else if (wr_done)
		begin
			if (hit_ctrl)
			begin
				ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
			end
			if (hit_blk1)
			begin
				block1_reg <= pwdata[23:0];
			end
			if (hit_blk2)
			begin
				block2_reg <= pwdata[23:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Rate dividers: a millisecond tick and the decoder clock tick.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt_reg <= 32'h00000000;
			ms_tick_reg <= 1'b0;
			dec_cnt_reg <= 32'h00000000;
			dec_tick_reg <= 1'b0;
		end
		else
		begin
			ms_tick_reg <= (ms_cnt_reg == 32'(CYC_PER_MS - 1));
			ms_cnt_reg <= (ms_cnt_reg == 32'(CYC_PER_MS - 1)) ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
			dec_tick_reg <= (dec_cnt_reg == 32'(DEC_DIV - 1));
			dec_cnt_reg <= (dec_cnt_reg == 32'(DEC_DIV - 1)) ? 32'h00000000 : dec_cnt_reg + 32'h00000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enables, battery sampling, monitor interrupt and transfer start.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			batt_meta_reg <= 1'b0;
			batt_sync_reg <= 1'b0;
			batt_sample_reg <= 1'b0;
			seen_fall_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			osc_en_reg <= 1'b0;
			rx_prev_reg <= 1'b0;
			mon_prev_reg <= 1'b0;
			irq_reg <= 1'b0;
			on_prev_reg <= 1'b0;
			start_pend_reg <= 1'b0;
		end
		else
		begin
			batt_meta_reg <= battery_sense_in;
			batt_sync_reg <= batt_meta_reg;
			if (rx_fall)
			begin
				batt_sample_reg <= batt_sync_reg;
				seen_fall_reg <= 1'b1;
			end
			rx_en_reg <= rx_next;
			osc_en_reg <= osc_next;
			rx_prev_reg <= rx_en_reg;
			mon_prev_reg <= mon_bit;
			// A change in the same cycle as the status read keeps the interrupt set.
			irq_reg <= mon_change || (irq_reg && !status_read);
			on_prev_reg <= dec_on;
			start_pend_reg <= (on_rise && synth_en) || (start_pend_reg && synth_busy);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	synth_shifter u_shifter
	(
		.pclk(pclk),
		.presetn(presetn),
		.start(start_pend_reg),
		.dec_tick(dec_tick_reg),
		.rate_sel(rate_sel),
		.block1(block1_reg),
		.block2(block2_reg),
		.busy(synth_busy),
		.synth_serial_data(synth_serial_data),
		.synth_serial_clock(synth_serial_clock),
		.synth_latch_pulse(synth_latch_pulse)
	);

	est_timer u_rx_timer
	(
		.pclk(pclk),
		.presetn(presetn),
		.enable(rx_en_reg),
		.ms_tick(ms_tick_reg),
		.target_ms(rx_target),
		.settled(rx_settled)
	);

	est_timer u_osc_timer
	(
		.pclk(pclk),
		.presetn(presetn),
		.enable(osc_en_reg),
		.ms_tick(ms_tick_reg),
		.target_ms(osc_target),
		.settled(osc_settled)
	);

	////////////////////////////////////////////////////////////////////////////////
	property p_start_once;
		@(posedge pclk) disable iff (!presetn)
		$rose(synth_busy) |-> $past(start_pend_reg) && $past(dec_on);
	endproperty
	a_start_once: assert property (p_start_once) else $error("Transfer started without an ON change.");

	property p_no_restart;
		@(posedge pclk) disable iff (!presetn)
		(dec_on && on_prev_reg && !start_pend_reg) |=> !start_pend_reg;
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("Transfer requested while staying ON.");

	property p_osc_during_synth;
		@(posedge pclk) disable iff (!presetn)
		synth_busy |=> osc_enable_out;
	endproperty
	a_osc_during_synth: assert property (p_osc_during_synth) else $error("Oscillator off during programming.");

	property p_force_both;
		@(posedge pclk) disable iff (!presetn)
		force_on |=> rx_enable_out && osc_enable_out;
	endproperty
	a_force_both: assert property (p_force_both) else $error("Forced mode did not hold both enables.");

	property p_rx_monitor_irq;
		@(posedge pclk) disable iff (!presetn)
		(mon_sel && $stable(mon_sel) && $changed(rx_enable_out)) |=> irq_out;
	endproperty
	a_rx_monitor_irq: assert property (p_rx_monitor_irq) else $error("Receiver enable change gave no interrupt.");

	property p_batt_only_on_fall;
		@(posedge pclk) disable iff (!presetn)
		!rx_fall |=> $stable(batt_sample_reg);
	endproperty
	a_batt_only_on_fall: assert property (p_batt_only_on_fall) else $error("Battery sampled outside a fall.");

	property p_batt_irq;
		@(posedge pclk) disable iff (!presetn)
		(!mon_sel && $stable(mon_sel) && $changed(batt_sample_reg)) |=> irq_out;
	endproperty
	a_batt_irq: assert property (p_batt_irq) else $error("Battery change gave no interrupt.");

	property p_batt_reset_zero;
		@(posedge pclk) disable iff (!presetn)
		!seen_fall_reg |-> !batt_sample_reg;
	endproperty
	a_batt_reset_zero: assert property (p_batt_reset_zero) else $error("Battery indicator set before any sample.");

	property p_irq_clear;
		@(posedge pclk) disable iff (!presetn)
		(status_read && !mon_change) |=> !irq_out;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("Interrupt stayed after status read.");
endmodule // synth_rx_control

// >>> synth_model.sv
`timescale 1ns/10ps

module synth_model
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Synthesizer pins.
	input wire logic synth_serial_data,
	input wire logic synth_serial_clock,
	input wire logic synth_latch_pulse,
	input wire logic osc_enable_out,
	// Captured words and timing.
	output logic [23:0] word1,
	output logic [23:0] word2,
	output int latches,
	output int low_13th,
	output int low_first,
	output logic bad
);
	logic [23:0] shift_reg;
	logic prev_clk;
	logic prev_data;
	logic prev_latch;
	int low_cnt;
	int bit_cnt;

	// The synthesizer shifts on rising clock edges and loads its dividers on the latch pulse.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{shift_reg, word1, word2, prev_clk, prev_data, prev_latch, bad} <= '0;
			{latches, low_13th, low_first, low_cnt, bit_cnt} <= '0;
		end
		else
		begin
			prev_clk <= synth_serial_clock;
			prev_data <= synth_serial_data;
			prev_latch <= synth_latch_pulse;
			low_cnt <= synth_serial_clock ? 0 : low_cnt + 1;
			if (synth_serial_clock && !prev_clk)
			begin
				shift_reg <= {shift_reg[22:0], synth_serial_data};
				bit_cnt <= bit_cnt + 1;
				if (bit_cnt == 12)
					low_13th <= low_cnt;
				if (bit_cnt == 0)
					low_first <= low_cnt;
			end
			if (synth_latch_pulse && !prev_latch)
			begin
				word1 <= word2;
				word2 <= shift_reg;
				latches <= latches + 1;
				bit_cnt <= 0;
			end
			// Data moving while the clock is high, or activity while unpowered, is flagged.
			if ((synth_serial_data !== prev_data && synth_serial_clock) ||
				((synth_serial_clock || synth_latch_pulse) && !osc_enable_out))
				bad <= 1'b1;
		end
	end
endmodule // synth_model

// >>> test_synth_rx_control.sv
`timescale 1ns/10ps
`include "synth_rx_control_consts.svh"

module test_synth_rx_control;
	import synth_rx_control_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_window_req = 0, battery_sense_in = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, err, rx_enable_out, osc_enable_out, irq_out, sd, sc, sl, bad;
	logic [23:0] word1, word2;
	int latches, low_13th, low_first, fails = 0, tests_run = 0;

	always #4 pclk = ~pclk;

	synth_rx_control #(.CYC_PER_MS(10), .DEC_DIV(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_window_req(rx_window_req), .battery_sense_in(battery_sense_in),
		.rx_enable_out(rx_enable_out), .osc_enable_out(osc_enable_out), .irq_out(irq_out),
		.synth_serial_data(sd), .synth_serial_clock(sc), .synth_latch_pulse(sl));

	synth_model i_model (.pclk(pclk), .presetn(presetn), .synth_serial_data(sd), .synth_serial_clock(sc),
		.synth_latch_pulse(sl), .osc_enable_out(osc_enable_out), .word1(word1), .word2(word2),
		.latches(latches), .low_13th(low_13th), .low_first(low_first), .bad(bad));

	////////////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the request stands until pready is seen high.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		apb(0, `ADDR_STATUS, 0);
		check(rd, 0);
		check({sd, sc, sl, rx_enable_out, osc_enable_out, irq_out}, 0);
		apb(0, 12'h010, 0);
		check({err, rd[30:0]}, 0 | 32'h80000000);
		apb(1, `ADDR_BLOCK1, 32'hFFFFFFFF);
		apb(0, `ADDR_BLOCK1, 0);
		check(rd, 32'h00FFFFFF);
		$display("t_reset done");
	endtask

	task t_synth(input logic [1:0] r);
		int p;
		int base;
		int n;
		p = (r == 0) ? `PAUSE_512 : (r == 1) ? `PAUSE_1200 : `PAUSE_2400;
		base = latches;
		apb(1, `ADDR_BLOCK1, {8'h00, 24'hA53C81 ^ {22'b0, r}});
		apb(1, `ADDR_BLOCK2, 32'h005AC37E);
		apb(1, `ADDR_CTRL, 32'h00000810 | ({30'b0, r} << `CTRL_RATE_LO));
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_BUSY], 1);
		check(rd[`STAT_OSC_EN], 1);
		for (n = 0; n < 4000 && latches < base + 2; n++)
			@(posedge pclk);
		wt(20);
		check(word1, 24'hA53C81 ^ {22'b0, r});
		check(word2, 24'h5AC37E);
		check(low_13th, (p + 1) * 4);
		check(low_first >= (p + 2) * 4, 1);
		check(bad, 0);
		// Writing the same ON value again must not start another transfer.
		apb(1, `ADDR_CTRL, 32'h00000810 | ({30'b0, r} << `CTRL_RATE_LO));
		wt(300);
		check(latches, base + 2);
		check({sd, sc, sl}, 0);
		apb(1, `ADDR_CTRL, 0);
		$display("t_synth rate %0d done", r);
	endtask

	task t_nosynth;
		int base;
		base = latches;
		apb(1, `ADDR_CTRL, 32'h00000010);
		wt(300);
		check(latches, base);
		apb(1, `ADDR_CTRL, 0);
		$display("t_nosynth done");
	endtask

	task t_force;
		apb(1, `ADDR_CTRL, 32'h00000008);
		wt(3);
		check({rx_enable_out, osc_enable_out}, 2'b11);
		wt(22);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_RX_SETTLED], 0);
		wt(50);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_RX_SETTLED], 1);
		check(rd[`STAT_OSC_SETTLED], 0);
		check(rd[`STAT_RX_EN +: 2], 2'b11);
		wt(150);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_OSC_SETTLED], 1);
		apb(1, `ADDR_CTRL, 0);
		wt(3);
		check({rx_enable_out, osc_enable_out}, 2'b00);
		apb(1, `ADDR_CTRL, 32'h00000070);
		wt(3);
		check({rx_enable_out, osc_enable_out}, 2'b01);
		rx_window_req <= 1;
		wt(3);
		check({rx_enable_out, osc_enable_out}, 2'b11);
		// The longest receiver establishment time is selected here.
		wt(250);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_RX_SETTLED], 0);
		wt(60);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_RX_SETTLED], 1);
		$display("t_force done");
	endtask

	task t_monitor;
		apb(1, `ADDR_CTRL, 32'h00000014);
		wt(5);
		apb(0, `ADDR_STATUS, 0);
		wt(3);
		check(irq_out, 0);
		rx_window_req <= 0;
		wt(5);
		check(irq_out, 1);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_MON], 0);
		wt(2);
		check(irq_out, 0);
		rx_window_req <= 1;
		wt(5);
		check(irq_out, 1);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_MON], 1);
		apb(1, `ADDR_CTRL, 32'h00000010);
		wt(5);
		apb(0, `ADDR_STATUS, 0);
		wt(2);
		battery_sense_in <= 1;
		wt(10);
		check(irq_out, 0);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_MON], 0);
		rx_window_req <= 0;
		wt(8);
		check(irq_out, 1);
		apb(0, `ADDR_STATUS, 0);
		check(rd[`STAT_MON], 1);
		$display("t_monitor done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#400000;
		fails++;
		final_report;
	end

	initial
	begin
		wt(8);
		presetn <= 1;
		t_reset;
		for (int r = 0; r < 4; r++)
			t_synth(r[1:0]);
		t_nosynth;
		t_force;
		t_monitor;
		final_report;
	end
endmodule // test_synth_rx_control
